// file: mdsm_node.sv
// Purpose: One node of a multidrop shared-memory network with token link
// Assumes: Host bus cycle decoded to simple strobes; link pins are registered
// Notes:   Memory is a flip-flop array sized small by a build parameter
//
// Summary of operation
// - Host writes go to local memory and into the transmit buffer together.
// - Received link data is written at the same relative address locally.
// - Node address comes from jumpers, readable in the status register.
// - Node with address zero acts as link arbiter, no other does.
// - Link ownership passes round robin from node zero to each node.
// - Owner sends its entire transmit buffer on taking the link.
// - Buffer empty: token returns to node zero, which sends then grants next.
// - Arbiter seizes link after 5 us silence, skipping dead nodes.
// - Three network interrupts, each with software function, level and vector.
// - One byte register write sends an interrupt to one node or all.
// - An interrupt can be raised on every node in one broadcast.
// - An interrupt is raised only where it is not already pending.
// - Interrupts travel in order behind earlier data writes.
// - Half-full transmit buffer raises an interrupt.
// - Status bit shows transmit buffer full.
// - Memory write while buffer full ends with bus error, data dropped.
// - Small memories send 1 Mbyte addresses, large ones 4 Mbyte addresses.
// - Transmit buffer depth is 512 transfers or 4 Kbyte by build choice.
// - Separate transmit and receive buffers absorb traffic peaks.
// - Memory takes 32, 16, 8 bit data; registers 8 bit only.
// - Link rate selectable: 25, 12.5, 6.25, 3.125 M words per second.
`include "mdsm_params.svh"
`timescale 1ns/1ps
module mdsm_node #(
   parameter int MEM_WORDS = 1024,
   parameter bit BUF_4K    = 1'b0,
   parameter int IDLE_CYC  = `MDSM_IDLE_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic [3:0]  i_jumper_addr,
   input  wire logic        i_mem_wr,
   input  wire logic        i_mem_rd,
   input  wire logic [21:0] i_mem_addr,
   input  wire logic [31:0] i_mem_wdata,
   input  wire logic [3:0]  i_mem_be,
   output logic [31:0]      o_mem_rdata,
   output logic             o_mem_ack,
   output logic             o_mem_berr,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [3:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   output logic [7:0]       o_reg_rdata,
   output logic [2:0]       o_net_irq,
   output logic             o_half_irq,
   input  wire logic        i_link_valid,
   input  wire mdsm_pkg::mdsm_kind_type i_link_kind,
   input  wire logic [3:0]  i_link_src,
   input  wire logic [3:0]  i_link_dst,
   input  wire logic [21:0] i_link_addr,
   input  wire logic [31:0] i_link_data,
   input  wire logic [3:0]  i_link_be,
   output logic             o_link_valid,
   output mdsm_pkg::mdsm_kind_type o_link_kind,
   output logic [3:0]       o_link_src,
   output logic [3:0]       o_link_dst,
   output logic [21:0]      o_link_addr,
   output logic [31:0]      o_link_data,
   output logic [3:0]       o_link_be,
   output logic             o_link_oe
);
   import mdsm_pkg::*;
   localparam int TAW   = BUF_4K ? `MDSM_BUF_AW_4K : `MDSM_BUF_AW;
   localparam int TDEP  = 1 << TAW;
   localparam int RAW   = `MDSM_RXF_AW;
   localparam int MAW   = $clog2(MEM_WORDS);
   localparam int TW    = 2 + 4 + 22 + 32 + 4;

   // Link pins pass two flops before use
   logic [TW:0] lk_s1_q, lk_s2_q;
   always_ff @(posedge i_clk) begin
      lk_s1_q <= {i_link_valid, i_link_kind, i_link_dst, i_link_addr, i_link_data, i_link_be};
      lk_s2_q <= lk_s1_q;
   end
   logic          rx_v;
   logic [1:0]    rx_k;
   logic [3:0]    rx_dst, rx_be;
   logic [21:0]   rx_addr;
   logic [31:0]   rx_data;
   assign {rx_v, rx_k, rx_dst, rx_addr, rx_data, rx_be} = lk_s2_q;

   // Control and configuration
   logic [7:0] ctl_q;
   logic [7:0] icfg_q [3];
   logic [7:0] ivec_q [3];
   logic [3:0] node_q;
   logic       arb_q;
   // Straps are pins: two flops before the address is trusted
   logic [3:0] jmp_s1_q, jmp_s2_q;
   always_ff @(posedge i_clk) begin
      jmp_s1_q <= i_jumper_addr;
      jmp_s2_q <= jmp_s1_q;
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         node_q <= 4'h0;
         arb_q  <= 1'b0;
      end else begin
         node_q <= jmp_s2_q;
         arb_q  <= (jmp_s2_q == 4'h0);
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctl_q <= `MDSM_CTL_RESET;
      end else if (i_reg_wr && i_reg_addr == `MDSM_REG_CONTROL) begin
         ctl_q <= i_reg_wdata;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_icfg
         always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
               icfg_q[gi] <= 8'h00;
               ivec_q[gi] <= 8'h00;
            end else if (i_reg_wr) begin
               if (i_reg_addr == 4'(`MDSM_REG_INT_CFG0 + gi))
                  icfg_q[gi] <= i_reg_wdata;
               if (i_reg_addr == 4'(`MDSM_REG_INT_VEC0 + gi))
                  ivec_q[gi] <= i_reg_wdata;
            end
         end
      end
   endgenerate
   logic wide;
   assign wide = ctl_q[`MDSM_CTL_WIDE_BIT];

   // Transmit buffer: data and interrupt entries share one queue for ordering
   logic [TW-1:0] tbuf_q [TDEP];
   logic [TAW:0]  twp_q, trp_q;
   logic          t_full, t_empty, t_push, t_pop;
   logic [TW-1:0] t_in;
   assign t_empty = (twp_q == trp_q);
   assign t_full  = (twp_q[TAW] != trp_q[TAW]) && (twp_q[TAW-1:0] == trp_q[TAW-1:0]);
   logic host_wr_ok, int_send;
   assign host_wr_ok = i_mem_wr && !t_full;
   assign int_send   = i_reg_wr && (i_reg_addr == `MDSM_REG_INT_SEND) && !t_full;
   logic [21:0] rel_addr;
   assign rel_addr = wide ? i_mem_addr : {2'b00, i_mem_addr[19:0]};
   always_comb begin
      t_push = host_wr_ok || int_send;
      t_in   = {MDSM_K_DATA, 4'h0, rel_addr, i_mem_wdata, i_mem_be};
      if (int_send) begin
         t_in = {MDSM_K_INT, i_reg_wdata[3:0], 20'h0, i_reg_wdata[7:6],
                 32'h0, i_reg_wdata[5:4], 2'b00};
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         twp_q <= '0;
      end else if (t_push) begin
         tbuf_q[twp_q[TAW-1:0]] <= t_in;
         twp_q <= twp_q + 1'b1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         trp_q <= '0;
      else if (t_pop)
         trp_q <= trp_q + 1'b1;
   end
   logic [TAW:0] t_cnt;
   assign t_cnt = twp_q - trp_q;
   logic half_q;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         half_q <= 1'b0;
      else
         half_q <= (t_cnt >= (TAW+1)'(TDEP / 2));
   end
   assign o_half_irq = half_q;

   // Receive buffer for link writes waiting on memory
   logic [57:0] rbuf_q [1 << RAW];
   logic [RAW:0] rwp_q, rrp_q;
   logic r_empty, r_push, r_pop;
   assign r_empty = (rwp_q == rrp_q);
   assign r_push = rx_v && (rx_k == MDSM_K_DATA);
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rwp_q <= '0;
      end else if (r_push) begin
         rbuf_q[rwp_q[RAW-1:0]] <= {rx_addr, rx_data, rx_be};
         rwp_q <= rwp_q + 1'b1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         rrp_q <= '0;
      else if (r_pop)
         rrp_q <= rrp_q + 1'b1;
   end

   // Memory: host has priority; link writes drain when host idle and no link write arrives that cycle
   logic [31:0] mem_q [MEM_WORDS];
   logic [57:0] r_head;
   assign r_head = rbuf_q[rrp_q[RAW-1:0]];
   logic host_use;
   assign host_use = host_wr_ok || i_mem_rd;
   assign r_pop = !r_empty && !host_use && !r_push;
   logic [MAW-1:0] m_idx;
   logic [31:0]    m_wd;
   logic [3:0]     m_be;
   logic           m_we;
   always_comb begin
      m_idx = i_mem_addr[MAW+1:2];
      m_wd  = i_mem_wdata;
      m_be  = i_mem_be;
      m_we  = host_wr_ok;
      if (r_pop) begin
         m_idx = r_head[MAW+37:38];
         m_wd  = r_head[35:4];
         m_be  = r_head[3:0];
         m_we  = 1'b1;
      end
   end
   // One process writes the array so no word has two drivers
   always_ff @(posedge i_clk) begin
      for (int b = 0; b < 4; b++) begin
         if (m_we && m_be[b])
            mem_q[m_idx][b*8 +: 8] <= m_wd[b*8 +: 8];
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_mem_rdata <= 32'h0;
         o_mem_ack   <= 1'b0;
         o_mem_berr  <= 1'b0;
      end else begin
         o_mem_rdata <= i_mem_rd ? mem_q[m_idx] : 32'h0;
         o_mem_ack   <= i_mem_rd || host_wr_ok;
         o_mem_berr  <= i_mem_wr && t_full;
      end
   end

   // Incoming interrupts, only where not already pending
   logic [2:0] ipend_q;
   logic [2:0] iset, iclr;
   logic [1:0] rx_ino;
   assign rx_ino = rx_addr[1:0];
   always_comb begin
      iset = 3'b000;
      iclr = 3'b000;
      if (rx_v && rx_k == MDSM_K_INT && rx_ino != 2'b11
          && (rx_be[3] || rx_dst == node_q))
         iset[rx_ino] = !ipend_q[rx_ino];
      if (i_reg_wr && i_reg_addr == `MDSM_REG_INT_PEND)
         iclr = i_reg_wdata[2:0];
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         ipend_q <= 3'b000;
      else
         ipend_q <= iset | (ipend_q & ~iclr);
   end
   generate
      for (gi = 0; gi < 3; gi++) begin : g_irq
         assign o_net_irq[gi] = ipend_q[gi] && icfg_q[gi][0];
      end
   endgenerate

   // Link rate divider
   logic [3:0] div_q;
   logic       tick;
   logic [3:0] div_max;
   assign div_max = (4'h1 << ctl_q[`MDSM_CTL_RATE_LSB +: 2]) * 4'h2 - 4'h1;
   assign tick = (div_q == 4'h0);
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         div_q <= 4'h0;
      else
         div_q <= tick ? div_max : div_q - 4'h1;
   end

   // Token arbiter and transmitter
   mdsm_state_type st_q;
   logic [3:0]  next_q;
   logic [15:0] idle_q;
   logic        tok_me;
   assign tok_me = rx_v && rx_k == MDSM_K_TOKEN && rx_dst == node_q;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !rx_v && !o_link_valid && idle_q != 16'hFFFF && idle_q < 16'(IDLE_CYC))
         idle_q <= (!i_rst_n || rx_v || o_link_valid) ? 16'h0 : idle_q + 16'h1;
      else if (rx_v || o_link_valid)
         idle_q <= 16'h0;
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q   <= MDSM_S_WAIT;
         next_q <= 4'h1;
      end else begin
         case (st_q)
            MDSM_S_WAIT: begin
               if (tok_me)
                  st_q <= MDSM_S_SEND;
               else if (arb_q && idle_q >= 16'(IDLE_CYC)) begin
                  // Target advances in PASS, so a dead node is skipped next time
                  st_q   <= MDSM_S_SEND;
               end
            end
            MDSM_S_SEND: if (t_empty && tick) st_q <= MDSM_S_PASS;
            MDSM_S_PASS: if (tick) begin
               st_q <= MDSM_S_WAIT;
               if (arb_q)
                  next_q <= (next_q == 4'hF) ? 4'h1 : next_q + 4'h1;
            end
            default: st_q <= MDSM_S_WAIT;
         endcase
      end
   end
   assign t_pop = (st_q == MDSM_S_SEND) && tick && !t_empty;
   logic [TW-1:0] t_head;
   assign t_head = tbuf_q[trp_q[TAW-1:0]];
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_link_valid <= 1'b0;
         o_link_kind  <= MDSM_K_IDLE;
         o_link_dst   <= 4'h0;
         o_link_addr  <= 22'h0;
         o_link_data  <= 32'h0;
         o_link_be    <= 4'h0;
      end else begin
         o_link_valid <= t_pop || (st_q == MDSM_S_PASS && tick);
         if (t_pop) begin
            o_link_kind <= mdsm_kind_type'(t_head[TW-1 -: 2]);
            {o_link_dst, o_link_addr, o_link_data, o_link_be} <= t_head[TW-3:0];
         end
         else if (st_q == MDSM_S_PASS && tick) begin
            o_link_kind <= MDSM_K_TOKEN;
            o_link_dst  <= arb_q ? next_q : 4'h0;
         end
      end
   end
   assign o_link_src = node_q;
   // Token word leaves after the state is back in WAIT; keep driving for it
   assign o_link_oe  = (st_q != MDSM_S_WAIT) || o_link_valid;

   // Register read, one cycle later, 8 bit
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         o_reg_rdata <= 8'h00;
      else if (i_reg_rd) begin
         case (i_reg_addr)
            `MDSM_REG_STATUS:  o_reg_rdata <= {t_full, half_q, arb_q, 1'b0, node_q};
            `MDSM_REG_CONTROL: o_reg_rdata <= ctl_q;
            `MDSM_REG_INT_PEND: o_reg_rdata <= {5'h0, ipend_q};
            4'h4, 4'h5, 4'h6:  o_reg_rdata <= icfg_q[i_reg_addr[1:0]];
            4'h8, 4'h9, 4'hA:  o_reg_rdata <= ivec_q[i_reg_addr[1:0]];
            default:           o_reg_rdata <= 8'h00;
         endcase
      end else
         o_reg_rdata <= 8'h00;
   end
endmodule

// file: mdsm_node_chk.sv
// Purpose: Port assertions for mdsm_node
// Assumes: Jumpers change rarely
// Notes:   Silence bound allows pipeline slack
`timescale 1ns/1ps
module mdsm_node_chk #(
   parameter int IDLE_CYC = 20
) (
   input wire logic       i_clk,
   input wire logic       i_rst_n,
   input wire logic [3:0] i_jumper_addr,
   input wire logic       i_mem_wr,
   input wire logic       i_mem_rd,
   input wire logic       o_mem_ack,
   input wire logic       o_mem_berr,
   input wire logic       i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       o_half_irq,
   input wire logic       i_link_valid,
   input wire logic       o_link_valid,
   input wire logic [3:0] o_link_src,
   input wire logic       o_link_oe
);
   int silent_q;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || i_link_valid || o_link_valid || i_jumper_addr != 4'h0) begin
         silent_q <= 0;
      end else begin
         silent_q <= silent_q + 1;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence jmp_steady;
      $stable(i_jumper_addr) [*4];
   endsequence
   a_rd_acked: assert property (i_mem_rd |=> o_mem_ack)
      else $error("memory read not acknowledged");
   a_wr_answer: assert property (i_mem_wr |=> (o_mem_ack != o_mem_berr))
      else $error("write got no single answer");
   a_full_half: assert property (o_mem_berr |-> o_half_irq)
      else $error("full buffer without half flag");
   a_src_node: assert property (jmp_steady ##0 o_link_valid |-> o_link_src == i_jumper_addr)
      else $error("link source differs from node");
   a_tx_pulse: assert property (o_link_valid |=> !o_link_valid)
      else $error("link words closer than fastest rate");
   a_tx_owner: assert property (o_link_valid |-> o_link_oe)
      else $error("word sent without link ownership");
   a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
      else $error("register data outside read slot");
   a_arb_silence: assert property (silent_q <= IDLE_CYC + 8)
      else $error("arbiter left link silent too long");
endmodule
bind mdsm_node mdsm_node_chk #(.IDLE_CYC(IDLE_CYC)) chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_jumper_addr(i_jumper_addr), .i_mem_wr(i_mem_wr), .i_mem_rd(i_mem_rd),
   .o_mem_ack(o_mem_ack), .o_mem_berr(o_mem_berr), .i_reg_rd(i_reg_rd),
   .o_reg_rdata(o_reg_rdata), .o_half_irq(o_half_irq), .i_link_valid(i_link_valid),
   .o_link_valid(o_link_valid), .o_link_src(o_link_src), .o_link_oe(o_link_oe));

// file: mdsm_params.svh
// Purpose: Constants for the multidrop shared-memory node
// Assumes: 50 MHz core clock
// Notes:   Offsets are register indexes on the plain register port
`ifndef MDSM_PARAMS_SVH
`define MDSM_PARAMS_SVH
`define MDSM_CLK_MHZ        50
`define MDSM_IDLE_NS        5000
`define MDSM_IDLE_CYC       ((`MDSM_IDLE_NS * `MDSM_CLK_MHZ) / 1000)
`define MDSM_NODES          16
`define MDSM_MEM_AW         20
`define MDSM_BUF_AW         9
`define MDSM_BUF_AW_4K      10
`define MDSM_RXF_AW         4
`define MDSM_REG_STATUS     4'h0
`define MDSM_REG_CONTROL    4'h1
`define MDSM_REG_INT_SEND   4'h2
`define MDSM_REG_INT_PEND   4'h3
`define MDSM_REG_INT_CFG0   4'h4
`define MDSM_REG_INT_VEC0   4'h8
`define MDSM_CTL_RATE_LSB   0
`define MDSM_CTL_BUF4K_BIT  2
`define MDSM_CTL_WIDE_BIT   3
`define MDSM_INT_ALL_BIT    7
`define MDSM_CTL_RESET      8'h00
`endif

// file: mdsm_peer.sv
// Purpose: Peer node driving the link input
// Assumes: Caller spaces the words
// Notes:   Released address and data lines carry inverted values so stale values never match
`timescale 1ns/1ps
module mdsm_peer (
   input  wire logic               i_clk,
   output logic                    o_valid,
   output mdsm_pkg::mdsm_kind_type o_kind,
   output logic [3:0]              o_src,
   output logic [3:0]              o_dst,
   output logic [21:0]             o_addr,
   output logic [31:0]             o_data,
   output logic [3:0]              o_be
);
   import mdsm_pkg::*;
   initial begin
      o_valid = 1'b0;
      o_kind = MDSM_K_IDLE;
      {o_src, o_dst, o_addr, o_data, o_be} = '0;
   end
   task automatic send(input mdsm_kind_type k, input logic [3:0] s, d,
                       input logic [21:0] a, input logic [31:0] v);
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_kind <= k; // Kind is driven as the caller passes it
      o_src <= s;
      o_dst <= d;
      o_addr <= a;
      o_data <= v;
      o_be <= 4'hF;
      @(posedge i_clk);
      o_valid <= 1'b0;
      o_kind <= MDSM_K_IDLE;
      o_addr <= ~a;
      o_data <= ~v;
      o_be <= 4'h0;
   endtask
endmodule

// file: mdsm_pkg.sv
// Purpose: Types for the multidrop shared-memory node
// Assumes: nothing
// Notes:   Link word kinds and arbiter states
package mdsm_pkg;
   typedef enum logic [1:0] {
      MDSM_K_DATA  = 2'b00,
      MDSM_K_INT   = 2'b01,
      MDSM_K_TOKEN = 2'b10,
      MDSM_K_IDLE  = 2'b11
   } mdsm_kind_type;
   typedef enum logic [1:0] {
      MDSM_S_WAIT = 2'b00,
      MDSM_S_SEND = 2'b01,
      MDSM_S_PASS = 2'b10
   } mdsm_state_type;
endpackage

// file: testbench.sv
// Purpose: Self-checking bench for mdsm_node
// Assumes: Rate 0 gives 2 clocks a word, buffer 512 deep
// Notes:   Data word dst is not compared
`timescale 1ns/1ps
module testbench;
   import mdsm_pkg::*;
   logic        clk = 0, rst_n = 0, mwr = 0, mrd = 0, rwr = 0, rrd = 0, mon = 1, was_d = 0;
   logic [3:0]  jmp = 4'h3, ra = 0;
   logic [21:0] ma = 0;
   logic [31:0] md = 0, d;
   logic [7:0]  rwd = 0, rrdata;
   logic [31:0] mrdata, pdat, ldat;
   logic        mack, mberr, hirq, lv, loe, pv;
   logic [2:0]  nirq;
   logic [3:0]  ps, pd, pbe, ls, ldst, lbe;
   logic [21:0] pa, la;
   mdsm_kind_type pk, lk;
   logic [59:0] w, e, m, txq[$];
   logic [31:0] mdl[int];
   int          bad_count = 0, checked = 0, per = 0, cyc = 0;
   time         last = 0;
   mdsm_node #(.IDLE_CYC(20)) mdsm_node_i (.i_clk(clk), .i_rst_n(rst_n), .i_jumper_addr(jmp),
      .i_mem_wr(mwr), .i_mem_rd(mrd), .i_mem_addr(ma), .i_mem_wdata(md), .i_mem_be(4'hF),
      .o_mem_rdata(mrdata), .o_mem_ack(mack), .o_mem_berr(mberr), .i_reg_wr(rwr),
      .i_reg_rd(rrd), .i_reg_addr(ra), .i_reg_wdata(rwd), .o_reg_rdata(rrdata),
      .o_net_irq(nirq), .o_half_irq(hirq), .i_link_valid(pv), .i_link_kind(pk),
      .i_link_src(ps), .i_link_dst(pd), .i_link_addr(pa), .i_link_data(pdat), .i_link_be(pbe),
      .o_link_valid(lv), .o_link_kind(lk), .o_link_src(ls), .o_link_dst(ldst),
      .o_link_addr(la), .o_link_data(ldat), .o_link_be(lbe), .o_link_oe(loe));
   mdsm_peer mdsm_peer_i (.i_clk(clk), .o_valid(pv), .o_kind(pk), .o_src(ps), .o_dst(pd),
      .o_addr(pa), .o_data(pdat), .o_be(pbe));
   always #10 clk = ~clk;
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 12000) begin
         bad_count++;
         conclude();
      end
   end
   task automatic check(input logic [59:0] s, x, input string msg);
      checked++;
      if (s !== x) begin
         bad_count++;
         $display("unexpected t=%0t %s: %h vs %h", $time, msg, s, x);
      end
   endtask
   always @(posedge clk) begin
      if (mon && lv) begin
         w = {lk, ldst, la, ldat};
         if (txq.size() == 0) check(0, 1, "extra word");
         else begin
            e = txq.pop_front();
            m = (lk == MDSM_K_DATA) ? 60'hC3F_FFFF_FFFF_FFFF : 60'hFC0_0000_0000_0000;
            check(w & m, e & m, "link word");
            if (per != 0 && lk == MDSM_K_DATA && was_d) check(($time - last) / 20, per, "rate");
         end
         last = $time;
         was_d = (lk == MDSM_K_DATA);
      end
   end
   task automatic mwrite(input logic [21:0] a, input logic [31:0] v, input logic ok);
      @(posedge clk);
      mwr <= 1'b1;
      ma <= a;
      md <= v;
      @(posedge clk);
      mwr <= 1'b0;
      #1 check({mack, mberr}, {ok, !ok}, "write answer");
      if (ok) begin
         mdl[a] = v;
         txq.push_back({MDSM_K_DATA, 4'h0, a, v});
      end
   endtask
   task automatic mread(input logic [21:0] a);
      @(posedge clk);
      mrd <= 1'b1;
      ma <= a;
      @(posedge clk);
      mrd <= 1'b0;
      #1 check(mrdata, mdl[a], "read data");
   endtask
   task automatic rreg(input logic [3:0] a, input logic [7:0] x, input logic wr);
      @(posedge clk);
      rwr <= wr;
      rrd <= !wr;
      ra <= a;
      rwd <= x;
      @(posedge clk);
      {rwr, rrd} <= 2'b00;
      #1 if (!wr) check(rrdata, x, "register");
   endtask
   task automatic drain();
      for (int n = 0; n < 3000 && txq.size() != 0; n++) @(posedge clk);
      check(txq.size(), 0, "drain");
   endtask
   initial begin
      void'($urandom(32'h1D20));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rreg(4'h0, 8'h03, 1'b0);
      rreg(4'h9, 8'h00, 1'b0);
      for (int i = 0; i < 4; i++) mwrite(22'(i * 4), $urandom, 1'b1);
      for (int i = 0; i < 4; i++) mread(22'(i * 4));
      d = $urandom;
      mdl[22'h100] = d;
      mdsm_peer_i.send(MDSM_K_DATA, 4'h5, 4'h0, 22'h100, d);
      repeat (8) @(posedge clk);
      mread(22'h100);
      rreg(4'h2, 8'h45, 1'b1);
      txq.push_back({MDSM_K_INT, 4'h5, 54'h0});
      txq.push_back({MDSM_K_TOKEN, 4'h0, 54'h0});
      mdsm_peer_i.send(MDSM_K_TOKEN, 4'h0, 4'h3, 22'h0, 32'h0);
      drain();
      $display("test basic done");
      rreg(4'h4, 8'h01, 1'b1);
      mdsm_peer_i.send(MDSM_K_INT, 4'h5, 4'h9, 22'h0, 32'h0);
      repeat (4) @(posedge clk);
      check(nirq, 3'b001, "irq raised");
      rreg(4'h3, 8'h01, 1'b0);
      rreg(4'h3, 8'h01, 1'b1);
      repeat (2) @(posedge clk);
      check(nirq, 3'b000, "irq cleared");
      $display("test irq done");
      rreg(4'h1, 8'h01, 1'b1);
      rreg(4'h1, 8'h01, 1'b0);
      per = 4;
      for (int i = 0; i < 512; i++) mwrite(22'(i * 4), $urandom, 1'b1);
      check(hirq, 1'b1, "half");
      mwrite(22'h800, $urandom, 1'b0);
      rreg(4'h0, 8'hC3, 1'b0);
      mread(22'h7FC);
      txq.push_back({MDSM_K_TOKEN, 4'h0, 54'h0});
      mdsm_peer_i.send(MDSM_K_TOKEN, 4'h0, 4'h3, 22'h0, 32'h0);
      drain();
      per = 0;
      rreg(4'h0, 8'h03, 1'b0);
      check(hirq, 1'b0, "half clear");
      $display("test fill done");
      jmp <= 4'h0;
      txq.push_back({MDSM_K_TOKEN, 4'h1, 54'h0});
      txq.push_back({MDSM_K_TOKEN, 4'h2, 54'h0});
      repeat (3) @(posedge clk);
      rreg(4'h0, 8'h20, 1'b0);
      drain();
      mon = 1'b0;
      $display("test arbiter done");
      conclude();
   end
endmodule
